// ### eeprom_wr_pkg.sv
package eeprom_wr_pkg;

	// array geometry
	localparam int PAGE_COUNT   = 128;
	localparam int PAGE_BYTES   = 16;
	localparam int PAGE_OFS_W   = $clog2(PAGE_BYTES);
	localparam int ADDR_W       = $clog2(PAGE_COUNT * PAGE_BYTES);
	localparam int ROW_W        = ADDR_W - PAGE_OFS_W;

	// device address byte fields
	localparam logic [3:0] DEV_TYPE_ARRAY  = 4'hA;
	localparam logic [3:0] DEV_TYPE_SERIAL = 4'hB;
	localparam logic [2:0] SERIAL_HI_BITS  = 3'h0;
	localparam int         DEV_TYPE_MSB    = 7;
	localparam int         DEV_TYPE_LSB    = 4;
	localparam int         DEV_HI_MSB      = 3;
	localparam int         DEV_HI_LSB      = 1;
	localparam int         DEV_RW_BIT      = 0;
	localparam logic [1:0] SERIAL_WORD_PATTERN = 2'h2;

	// bit counter phases inside one byte
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
	localparam logic [3:0] BIT_CNT_ACK  = 4'h8;
	localparam logic [3:0] BIT_CNT_DONE = 4'h9;

	// write cycle timing; the value is a plain default, not a device figure
	localparam int CLK_FREQ_MHZ        = 100;
	localparam int WRITE_CYCLE_TIME_US = 1000;
	localparam int WRITE_CYCLE_CYCLES  = WRITE_CYCLE_TIME_US * CLK_FREQ_MHZ;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_DEV  = 5'h02,
		ST_WORD = 5'h04,
		ST_DATA = 5'h08,
		ST_SKIP = 5'h10
	} bus_state_t;

	typedef struct packed {
		logic              serial;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} load_word_t;

endpackage

// ### bus_cond_detect.sv
`timescale 1ns/1ps
`default_nettype none
module bus_cond_detect import eeprom_wr_pkg::*; (
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_rise_o,
	output logic      scl_fall_o,
	output logic      start_o,
	output logic      stop_o
);
	logic scl_prev_reg;
	logic sda_prev_reg;

	// idle bus is high on both lines, so reset to that
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_i;
			sda_prev_reg <= sda_i;
		end
	end

	assign scl_rise_o = scl_i && !scl_prev_reg;
	assign scl_fall_o = !scl_i && scl_prev_reg;
	assign start_o    = scl_i && scl_prev_reg && sda_prev_reg && !sda_i;
	assign stop_o     = scl_i && scl_prev_reg && !sda_prev_reg && sda_i;
endmodule // bus_cond_detect
`default_nettype wire

// ### two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	logic             skid_valid_reg;
	logic [WIDTH-1:0] skid_data_reg;
	logic             take_in;

	// ready is registered: a second word is caught by the skid entry
	assign in_ready_o = !skid_valid_reg;
	assign take_in    = in_valid_i && !skid_valid_reg;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_valid_o    <= 1'b0;
			out_data_o     <= '0;
			skid_valid_reg <= 1'b0;
			skid_data_reg  <= '0;
		end else if (!out_valid_o || out_ready_i) begin
			if (skid_valid_reg) begin
				out_data_o     <= skid_data_reg;
				out_valid_o    <= 1'b1;
				skid_valid_reg <= 1'b0;
			end else begin
				out_data_o  <= in_data_i;
				out_valid_o <= take_in;
			end
		end else if (take_in) begin
			skid_data_reg  <= in_data_i;
			skid_valid_reg <= 1'b1;
		end
	end
endmodule // two_entry_buffer
`default_nettype wire

// ### eeprom_wr_slave.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_wr_slave import eeprom_wr_pkg::*; #(
	parameter int WR_CYCLES = WRITE_CYCLE_CYCLES
) (
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	input  wire logic wp_i,
	output logic      load_valid_o,
	output load_word_t load_word_o,
	input  wire logic load_ready_i,
	output logic      commit_o,
	output logic      discard_o,
	output logic      busy_o
);
	localparam int TIMER_W = $clog2(WR_CYCLES + 1);

	bus_state_t          state_reg;
	logic [7:0]          shift_reg;
	logic [3:0]          bit_cnt_reg;
	logic [ADDR_W-1:0]   addr_reg;
	logic                serial_reg;
	logic                have_data_reg;
	logic                sda_oe_reg;
	logic                busy_reg;
	logic [TIMER_W-1:0]  timer_reg;
	logic                commit_reg;
	logic                discard_reg;

	logic                scl_rise;
	logic                scl_fall;
	logic                start_cond;
	logic                stop_cond;
	logic                decide;
	logic                release_ack;
	logic                dev_array;
	logic                dev_serial;
	logic                dev_match;
	logic                ack_ok;
	logic                push_fire;
	logic                buf_in_ready;
	load_word_t          push_word;

	bus_cond_detect u_detect (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (start_cond),
		.stop_o     (stop_cond)
	);

	// byte ends at the fall of the eighth clock; ack bit ends at the ninth fall
	assign decide      = scl_fall && (bit_cnt_reg == BIT_CNT_ACK);
	assign release_ack = scl_fall && (bit_cnt_reg == BIT_CNT_DONE);

	assign dev_array  = shift_reg[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_ARRAY;
	assign dev_serial = (shift_reg[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_SERIAL)
		&& (shift_reg[DEV_HI_MSB:DEV_HI_LSB] == SERIAL_HI_BITS);
	assign dev_match  = dev_array || dev_serial;

	always_comb begin
		ack_ok = 1'b0;
		case (state_reg)
			ST_DEV:  ack_ok = dev_match && !busy_reg;
			ST_WORD: ack_ok = 1'b1;
			ST_DATA: ack_ok = buf_in_ready;
			default: ack_ok = 1'b0;
		endcase
	end

	assign push_fire = decide && (state_reg == ST_DATA) && buf_in_ready;
	assign push_word = '{serial: serial_reg, addr: addr_reg, data: shift_reg};

	// bus state walk; start and stop override everything
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_IDLE;
		end else if (start_cond) begin
			// a Start inside the cycle is not taken, so a poll byte ending late gets no ack
			state_reg <= busy_reg ? ST_SKIP : ST_DEV;
		end else if (stop_cond) begin
			state_reg <= ST_IDLE;
		end else if (release_ack) begin
			case (state_reg)
				ST_DEV: begin
					if (!sda_oe_reg) begin
						state_reg <= ST_SKIP;
					end else if (shift_reg[DEV_RW_BIT]) begin
						state_reg <= ST_SKIP;
					end else begin
						state_reg <= ST_WORD;
					end
				end
				ST_WORD: state_reg <= ST_DATA;
				ST_DATA: state_reg <= sda_oe_reg ? ST_DATA : ST_SKIP;
				default: state_reg <= state_reg;
			endcase
		end
	end

	// bit capture on the clock rise, most significant bit first
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			shift_reg   <= '0;
			bit_cnt_reg <= BIT_CNT_ZERO;
		end else if (start_cond || stop_cond) begin
			bit_cnt_reg <= BIT_CNT_ZERO;
		end else if (scl_rise && (bit_cnt_reg < BIT_CNT_ACK)) begin
			shift_reg   <= {shift_reg[6:0], sda_i};
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end else if (decide) begin
			bit_cnt_reg <= BIT_CNT_DONE;
		end else if (release_ack) begin
			bit_cnt_reg <= BIT_CNT_ZERO;
		end
	end

	// ack drive changes only on the clock fall, except that a Start or Stop drops it
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sda_oe_reg <= 1'b0;
		end else if (start_cond || stop_cond || release_ack) begin
			sda_oe_reg <= 1'b0;
		end else if (decide) begin
			sda_oe_reg <= ack_ok && (state_reg != ST_IDLE) && (state_reg != ST_SKIP);
		end
	end

	// address pointer: top bits from the device byte, low byte from the word byte
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			addr_reg   <= '0;
			serial_reg <= 1'b0;
		end else if (decide && (state_reg == ST_DEV) && dev_match && !busy_reg) begin
			serial_reg <= dev_serial;
			if (dev_array) begin
				addr_reg[ADDR_W-1:ADDR_W-3] <= shift_reg[DEV_HI_MSB:DEV_HI_LSB];
			end else begin
				addr_reg[ADDR_W-1:ADDR_W-3] <= SERIAL_HI_BITS;
			end
		end else if (decide && (state_reg == ST_WORD)) begin
			addr_reg[7:0] <= shift_reg;
		end else if (push_fire) begin
			// only the page offset counts, so the row never changes
			addr_reg[PAGE_OFS_W-1:0] <= addr_reg[PAGE_OFS_W-1:0] + 4'h1;
		end
	end

	// a complete acked data byte arms the Stop; anything else leaves it idle
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			have_data_reg <= 1'b0;
		end else if (start_cond || stop_cond) begin
			have_data_reg <= 1'b0;
		end else if (push_fire) begin
			have_data_reg <= 1'b1;
		end
	end

	// protect level is looked at only in the Stop cycle
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			commit_reg  <= 1'b0;
			discard_reg <= 1'b0;
		end else begin
			commit_reg  <= stop_cond && have_data_reg && !wp_i && !serial_reg;
			// serial region is read-only, so loaded bytes are dropped too
			discard_reg <= stop_cond && have_data_reg && (wp_i || serial_reg);
		end
	end

	// self-timed cycle; protect changes after the Stop cannot reach it
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_reg  <= 1'b0;
			timer_reg <= '0;
		end else if (busy_reg) begin
			if (timer_reg == '0) begin
				busy_reg <= 1'b0;
			end else begin
				timer_reg <= timer_reg - 1'b1;
			end
		end else if (stop_cond && have_data_reg && !wp_i && !serial_reg) begin
			busy_reg  <= 1'b1;
			timer_reg <= TIMER_W'(WR_CYCLES - 1);
		end
	end

	// a full buffer answers with nack, which the master sees as a lost byte
	two_entry_buffer #(
		.WIDTH ($bits(load_word_t))
	) u_buffer (
		.core_clk_i  (core_clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (push_fire),
		.in_data_i   (push_word),
		.in_ready_o  (buf_in_ready),
		.out_valid_o (load_valid_o),
		.out_data_o  (load_word_o),
		.out_ready_i (load_ready_i)
	);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	assign sda_oe_o  = sda_oe_reg;
	assign commit_o  = commit_reg;
	assign discard_o = discard_reg;
	assign busy_o    = busy_reg;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_dev_nomatch: assert property (
		decide && (state_reg == ST_DEV) && !dev_match |=> !sda_oe_reg)
		else $error("device byte that fails the compare was acked");

	a_dev_match_ack: assert property (
		decide && (state_reg == ST_DEV) && dev_array && !busy_reg && !start_cond
		|=> sda_oe_reg)
		else $error("array device byte was not acked");

	a_busy_silent: assert property (
		busy_reg |-> !sda_oe_reg)
		else $error("device drove the bus while programming");

	a_poll_nack: assert property (
		start_cond && busy_reg |=> (state_reg == ST_SKIP) && !sda_oe_reg)
		else $error("Start during programming was taken");

	a_hi_addr: assert property (
		decide && (state_reg == ST_DEV) && dev_array && !busy_reg
		|=> addr_reg[ADDR_W-1:ADDR_W-3] == $past(shift_reg[DEV_HI_MSB:DEV_HI_LSB]))
		else $error("top address bits not taken from device byte");

	a_dir_select: assert property (
		release_ack && (state_reg == ST_DEV) && sda_oe_reg && !start_cond && !stop_cond
		|=> state_reg == ($past(shift_reg[DEV_RW_BIT]) ? ST_SKIP : ST_WORD))
		else $error("direction bit steered the wrong way");

	a_page_wrap: assert property (
		push_fire |=> (addr_reg[PAGE_OFS_W-1:0] == $past(addr_reg[PAGE_OFS_W-1:0]) + 4'h1)
			&& (addr_reg[ADDR_W-1:PAGE_OFS_W] == $past(addr_reg[ADDR_W-1:PAGE_OFS_W])))
		else $error("write address left its page");

	a_cycle_start: assert property (
		stop_cond && have_data_reg && !wp_i && !serial_reg |=> commit_reg && busy_reg ##1 busy_reg)
		else $error("Stop after data did not start programming");

	a_wp_blocks: assert property (
		stop_cond && have_data_reg && wp_i |=> discard_reg && !busy_reg && !commit_reg)
		else $error("protected write started a cycle");

	a_no_data_idle: assert property (
		stop_cond && !have_data_reg && !busy_reg |=> !busy_reg && !commit_reg && !discard_reg)
		else $error("Stop without data started a cycle");

	a_ack_on_fall: assert property (
		$rose(sda_oe_reg) |-> $past(scl_fall))
		else $error("ack drive began outside a clock fall");

	a_busy_len: assert property (
		$fell(busy_reg) |-> $past(timer_reg) == '0)
		else $error("programming ended before its count ran out");

	a_skip_quiet: assert property (
		state_reg == ST_SKIP |=> !$rose(sda_oe_reg))
		else $error("ignored byte was acked");

	a_word_low: assert property (
		decide && (state_reg == ST_WORD) |=> addr_reg[7:0] == $past(shift_reg))
		else $error("low address byte not taken from word byte");

	a_word_ack: assert property (
		decide && (state_reg == ST_WORD) |=> sda_oe_reg)
		else $error("word address byte was not acked");

	a_serial_top: assert property (
		decide && (state_reg == ST_DEV) && dev_serial && !busy_reg
		|=> serial_reg && (addr_reg[ADDR_W-1:ADDR_W-3] == SERIAL_HI_BITS))
		else $error("serial device byte did not select the serial region");

	a_serial_drop: assert property (
		stop_cond && have_data_reg && serial_reg |=> discard_reg && !busy_reg && !commit_reg)
		else $error("serial region write started a cycle");

	a_wp_ignored: assert property (
		busy_reg && (timer_reg != '0) |=> busy_reg)
		else $error("programming cut short");

	a_ack_hold: assert property (
		sda_oe_reg && !scl_fall && !start_cond && !stop_cond |=> sda_oe_reg)
		else $error("ack released outside a clock fall");

	a_data_ack: assert property (
		decide && (state_reg == ST_DATA) && buf_in_ready |=> sda_oe_reg)
		else $error("data byte with room was not acked");

	a_commit_pulse: assert property (
		commit_reg |=> !commit_reg)
		else $error("commit pulse longer than one cycle");

	a_nack_skip: assert property (
		release_ack && (state_reg == ST_DEV) && !sda_oe_reg |=> state_reg == ST_SKIP)
		else $error("refused device byte did not release the bus");

	a_stop_idle: assert property (
		stop_cond |=> (state_reg == ST_IDLE) && !sda_oe_reg)
		else $error("Stop did not end the transfer");

	c_byte_write: cover property (commit_reg);
	c_protected:  cover property (discard_reg);
	c_poll_nack:  cover property (busy_reg && start_cond);
	c_buf_full:   cover property (!buf_in_ready && !load_ready_i);
	c_serial_drop: cover property (discard_reg && serial_reg);
endmodule // eeprom_wr_slave
`default_nettype wire

// ### bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	input  wire logic core_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	localparam int HALF = 3;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	// also a repeated start: sda is raised while scl is still low
	task automatic start_cond();
		tick(1);
		sda_o = 1'b1;
		tick(HALF);
		scl_o = 1'b1;
		tick(HALF);
		sda_o = 1'b0;
		tick(HALF);
		scl_o = 1'b0;
	endtask

	task automatic stop_cond();
		tick(1);
		sda_o = 1'b0;
		tick(HALF);
		scl_o = 1'b1;
		tick(HALF);
		sda_o = 1'b1;
		tick(HALF);
	endtask

	// data changes only while scl is low
	task automatic clock_bit(input logic b, output logic seen);
		tick(1);
		sda_o = b;
		tick(HALF);
		scl_o = 1'b1;
		tick(1);
		seen = sda_i;
		tick(HALF);
		scl_o = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
		clock_bit(1'b1, s);
		ack = ~s;
	endtask
endmodule // bus_master_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import eeprom_wr_pkg::*;;
	localparam int WRC = 40;
	logic       core_clk_i, sys_rst_i, scl, sda_m, sda_bus, sda_o, sda_oe_o;
	logic       wp_i, load_valid_o, load_ready_i, commit_o, discard_o, busy_o;
	load_word_t load_word_o;
	load_word_t exp_q[$];
	int         miscompares = 0, total_checks = 0;
	int         n_commit = 0, n_discard = 0, c_base, d_base;

	// open drain with pull-up
	assign sda_bus = sda_m & ~sda_oe_o;

	eeprom_wr_slave #(.WR_CYCLES(WRC)) uut (.core_clk_i, .sys_rst_i, .scl_i(scl),
		.sda_i(sda_bus), .sda_o, .sda_oe_o, .wp_i, .load_valid_o, .load_word_o,
		.load_ready_i, .commit_o, .discard_o, .busy_o);
	bus_master_model u_master (.core_clk_i, .sda_i(sda_bus), .scl_o(scl), .sda_o(sda_m));

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic fail(input string m);
		miscompares++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask
	task automatic chk_bit(input logic g, input logic e, input string m);
		total_checks++;
		if (g !== e) fail(m);
	endtask
	task automatic chk_word(input load_word_t g, input load_word_t e);
		total_checks++;
		if (g !== e) fail("load word");
	endtask
	task automatic chk_cnt(input int g, input int e, input string m);
		total_checks++;
		if (g != e) fail(m);
	endtask
	task automatic end_of_test();
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge core_clk_i) begin
		if (commit_o === 1'b1) n_commit++;
		if (discard_o === 1'b1) n_discard++;
		if (load_valid_o === 1'b1 && load_ready_i === 1'b1) begin
			if (exp_q.size() == 0) fail("extra load word");
			else chk_word(load_word_o, exp_q.pop_front());
		end
	end

	task automatic send(input logic [7:0] b, input logic e);
		logic ack;
		u_master.send_byte(b, ack);
		chk_bit(ack, e, "ack");
	endtask
	task automatic mark();
		c_base = n_commit;
		d_base = n_discard;
	endtask
	task automatic settle(input int c, input int d, input logic b);
		u_master.tick(2);
		chk_cnt(n_commit - c_base, c, "commit count");
		chk_cnt(n_discard - d_base, d, "discard count");
		chk_bit(busy_o, b, "busy");
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 200 && busy_o !== 1'b0; i++) u_master.tick(1);
		if (i == 200) begin
			fail("busy timeout");
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] dev, input logic [7:0] word, input int n,
		input logic [7:0] d0);
		logic [10:0] a;
		logic [7:0]  d;
		logic        ser;
		ser = (dev[7:4] === DEV_TYPE_SERIAL);
		a = ser ? {3'h0, word} : {dev[3:1], word};
		d = d0;
		u_master.start_cond();
		send(dev, 1'b1);
		send(word, 1'b1);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back('{ser, a, d});
			send(d, 1'b1);
			a[3:0] = a[3:0] + 4'h1;
			d = d + 8'h01;
		end
		u_master.stop_cond();
	endtask

	task automatic s_byte_write();
		mark();
		wr(8'hAA, 8'h3C, 1, 8'hA5);
		settle(1, 0, 1'b1);
		u_master.start_cond();
		send(8'hA0, 1'b0);
		u_master.start_cond();
		chk_bit(busy_o, 1'b0, "busy end");
		send(8'hA0, 1'b1);
		u_master.stop_cond();
		settle(1, 0, 1'b0);
	endtask

	task automatic s_page_wrap();
		mark();
		wr(8'hA6, 8'h7E, 17, 8'h10);
		settle(1, 0, 1'b1);
		chk_cnt(exp_q.size(), 0, "words left");
		wait_idle();
	endtask

	// type codes, serial high bits and direction; then a write with no data
	task automatic s_dev_codes();
		logic [7:0] dev[7] = '{8'h90, 8'hC0, 8'hB2, 8'hBE, 8'hA1, 8'hB1, 8'hA0};
		logic [6:0] ok = 7'h70;
		mark();
		for (int i = 0; i < 7; i++) begin
			u_master.start_cond();
			send(dev[i], ok[i]);
			u_master.stop_cond();
		end
		u_master.start_cond();
		send(8'hA4, 1'b1);
		send(8'h11, 1'b1);
		u_master.stop_cond();
		settle(0, 0, 1'b0);
	endtask

	task automatic s_serial();
		mark();
		wr(8'hB0, 8'h80, 1, 8'h5A);
		settle(0, 1, 1'b0);
	endtask

	task automatic s_protect();
		mark();
		wp_i = 1'b1;
		wr(8'hA2, 8'h20, 2, 8'hC0);
		settle(0, 1, 1'b0);
		u_master.start_cond();
		send(8'hA0, 1'b1);
		u_master.stop_cond();
		wp_i = 1'b0;
		mark();
		wr(8'hA2, 8'h30, 1, 8'h77);
		wp_i = 1'b1;
		settle(1, 0, 1'b1);
		u_master.tick(20);
		chk_bit(busy_o, 1'b1, "busy held");
		wp_i = 1'b0;
		wait_idle();
	endtask

	// core stalls: two words fit, the third data byte is refused
	task automatic s_buffer_full();
		mark();
		load_ready_i = 1'b0;
		u_master.start_cond();
		send(8'hA0, 1'b1);
		send(8'h40, 1'b1);
		exp_q.push_back('{1'b0, 11'h040, 8'h11});
		exp_q.push_back('{1'b0, 11'h041, 8'h22});
		send(8'h11, 1'b1);
		send(8'h22, 1'b1);
		send(8'h33, 1'b0);
		u_master.stop_cond();
		settle(1, 0, 1'b1);
		load_ready_i = 1'b1;
		u_master.tick(4);
		chk_cnt(exp_q.size(), 0, "drain");
		wait_idle();
	endtask

	// reset in mid-cycle ends it; the device answers at once afterwards
	task automatic s_reset_busy();
		mark();
		wr(8'hA0, 8'h05, 1, 8'h3E);
		settle(1, 0, 1'b1);
		sys_rst_i = 1'b1;
		u_master.tick(2);
		sys_rst_i = 1'b0;
		u_master.tick(2);
		chk_bit(sda_oe_o, 1'b0, "ack after reset");
		chk_bit(busy_o, 1'b0, "busy after reset");
		u_master.start_cond();
		send(8'hA0, 1'b1);
		u_master.stop_cond();
		settle(1, 0, 1'b0);
	endtask

	initial begin
		sys_rst_i = 1'b1;
		wp_i = 1'b0;
		load_ready_i = 1'b1;
		repeat (12) @(posedge core_clk_i);
		#1;
		sys_rst_i = 1'b0;
		u_master.tick(2);
		chk_bit(sda_oe_o, 1'b0, "reset release");
		chk_bit(sda_o, 1'b0, "data level");
		chk_bit(busy_o, 1'b0, "reset busy");
		chk_bit(load_valid_o, 1'b0, "reset valid");
		s_byte_write();
		s_page_wrap();
		s_dev_codes();
		s_serial();
		s_protect();
		s_buffer_full();
		s_reset_busy();
		end_of_test();
	end

	initial begin
		repeat (100000) @(posedge core_clk_i);
		fail("timeout");
		end_of_test();
	end
endmodule // tb
`default_nettype wire
